// ==== logic/icmb_params.svh ====
// constants of the inter-core mailbox: offsets, fields, reset values, queue shape
//
// Notes on behaviour
// [R1] two independent queues, eight 32-bit words each
// [R2] core zero fills one, core one the other
// [R3] pop when empty ignored, sets bit 3
// [R4] push when full discarded, sets bit 2
// [R5] bit 1: own outgoing queue not full
// [R6] bit 0: own incoming queue not empty
// [R7] interrupt from valid and errors; clear errors only
// [R8] valid drops only when the queue empties
// [R9] core drains by popping until valid clears
// [R10] sender checks ready before every push
// [R11] receiver checks valid before every pop
// [R12] each pop returns the head word, removes it
// [R13] fifo order; reset empties queues, clears flags
`ifndef ICMB_PARAMS_SVH
`define ICMB_PARAMS_SVH

// ---------------------------------------------------------------
// queue shape
// ---------------------------------------------------------------
`define ICMB_WORD_W      32
`define ICMB_QUEUE_DEPTH 8
`define ICMB_BUF_DEPTH   16
`define ICMB_ADR_W       8

// ---------------------------------------------------------------
// register map: one bank per core, selected by the bank bit
// ---------------------------------------------------------------
`define ICMB_BANK_BIT    4
`define ICMB_OFS_STATUS  2'h0
`define ICMB_OFS_TXDATA  2'h1
`define ICMB_OFS_RXDATA  2'h2

// ---------------------------------------------------------------
// status fields
// ---------------------------------------------------------------
`define ICMB_ST_RXVALID  0
`define ICMB_ST_TXREADY  1
`define ICMB_ST_WRFULL   2
`define ICMB_ST_RDEMPTY  3

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define ICMB_RST_FLAG    1'b0
`define ICMB_RST_WORD    32'h0000_0000
`define ICMB_SEL_ALL     4'hF

`endif

// ==== logic/icmb_pkg.sv ====
// types shared by the inter-core mailbox files
`default_nettype none
`include "icmb_params.svh"

package icmb_pkg;

    typedef logic [`ICMB_WORD_W-1:0] icmb_word_t;
    typedef logic [`ICMB_ADR_W-1:0]  icmb_addr_t;
    typedef logic [3:0]              icmb_sel_t;
    typedef logic [1:0]              icmb_pair_t;

    typedef enum logic [1:0]
    {
        ICMB_REG_STATUS,
        ICMB_REG_TXDATA,
        ICMB_REG_RXDATA,
        ICMB_REG_NONE
    } icmb_reg_t;

endpackage

`default_nettype wire

// ==== logic/icmb_fifo.sv ====
// synchronous flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module icmb_fifo
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
)
(
    input  wire logic             clock,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wrPtr_q;
    logic [PW-1:0]    rdPtr_q;
    logic [CW-1:0]    count_q;
    logic             push;
    logic             pop;

    assign inReady  = (count_q != CW'(DEPTH));
    assign outValid = (count_q != '0);
    assign outData  = mem_q[rdPtr_q];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    // ---------------------------------------------------------------
    // storage, one entry per slot
    // ---------------------------------------------------------------
    genvar e;
    generate
        for (e = 0; e < DEPTH; e++)
        begin : gSlot
            always_ff @(posedge clock or negedge arst_n)
            begin
                if (!arst_n)
                    mem_q[e] <= '0;
                else if (push && (wrPtr_q == PW'(e)))
                    mem_q[e] <= inData;
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // pointers and fill level
    // ---------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end
        else
        begin
            if (push)
                wrPtr_q <= (wrPtr_q == PW'(DEPTH - 1)) ? '0 : wrPtr_q + PW'(1);
            if (pop)
                rdPtr_q <= (rdPtr_q == PW'(DEPTH - 1)) ? '0 : rdPtr_q + PW'(1);
            if (push && !pop)
                count_q <= count_q + CW'(1);
            else if (pop && !push)
                count_q <= count_q - CW'(1);
        end
    end

endmodule

`default_nettype wire

// ==== logic/icmb_mailbox.sv ====
// inter-core mailbox: two word queues behind one classic wishbone slave
`timescale 1ns/1ps
`default_nettype none

module icmb_mailbox
(
    input  wire logic                 clock,
    input  wire logic                 arst_n,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire icmb_pkg::icmb_addr_t wb_adr_i,
    input  wire icmb_pkg::icmb_sel_t  wb_sel_i,
    input  wire icmb_pkg::icmb_word_t wb_dat_i,
    output icmb_pkg::icmb_word_t      wb_dat_o,
    output logic                      wb_ack_o,
    output icmb_pkg::icmb_pair_t      coreIrq
);

    import icmb_pkg::*;

    // ---------------------------------------------------------------
    // request decode
    // ---------------------------------------------------------------
    logic       request;
    logic       bank;
    icmb_reg_t  regSel;
    logic       wordAligned;
    logic       fullWord;

    logic       ack_q;
    icmb_word_t rdData_q;
    icmb_pair_t irq_q;

    // a request is taken once; the cycle with ack high must not repeat it
    assign request     = wb_cyc_i && wb_stb_i && !ack_q;
    assign bank        = wb_adr_i[`ICMB_BANK_BIT];
    assign wordAligned = (wb_adr_i[1:0] == 2'h0)
                         && (wb_adr_i[`ICMB_ADR_W-1:`ICMB_BANK_BIT+1] == '0);
    assign fullWord    = (wb_sel_i == `ICMB_SEL_ALL);

    always_comb
    begin
        regSel = ICMB_REG_NONE;
        if (wordAligned)
        begin
            case (wb_adr_i[3:2])
                `ICMB_OFS_STATUS: regSel = ICMB_REG_STATUS;
                `ICMB_OFS_TXDATA: regSel = ICMB_REG_TXDATA;
                `ICMB_OFS_RXDATA: regSel = ICMB_REG_RXDATA;
                default:          regSel = ICMB_REG_NONE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // the two queues; queue c is filled by core c, drained by the other
    // ---------------------------------------------------------------
    icmb_pair_t qInValid;
    icmb_pair_t qInReady;
    icmb_pair_t qOutValid;
    icmb_pair_t qOutReady;
    icmb_word_t qOutData [2];

    // per-core view of the queues
    icmb_pair_t txReady;
    icmb_pair_t rxValid;
    icmb_word_t rxHead [2];
    icmb_pair_t pushReq;
    icmb_pair_t popReq;
    icmb_pair_t clearReq;

    icmb_pair_t wrFull_q;
    icmb_pair_t rdEmpty_q;

    genvar c;
    generate
        for (c = 0; c < 2; c++)
        begin : gCore
            // core c owns the push side of queue c only
            assign qInValid[c] = pushReq[c];                                 // [R2]
            // the pop side of queue c belongs to the other core
            assign qOutReady[c] = popReq[1-c] && qOutValid[c];               // [R2]

            assign txReady[c] = qInReady[c];                                 // [R5]
            assign rxValid[c] = qOutValid[1-c];                              // [R6]
            assign rxHead[c]  = qOutData[1-c];                               // [R12]

            assign pushReq[c]  = request && wb_we_i && (bank == c)
                                 && (regSel == ICMB_REG_TXDATA) && fullWord;
            assign popReq[c]   = request && !wb_we_i && (bank == c)
                                 && (regSel == ICMB_REG_RXDATA);
            assign clearReq[c] = request && wb_we_i && (bank == c)
                                 && (regSel == ICMB_REG_STATUS);

            // eight words per queue; the flops form a ring that is read back in arrival order
            icmb_fifo
            #(
                .WIDTH (`ICMB_WORD_W),
                .DEPTH (`ICMB_QUEUE_DEPTH)
            )
            uQueue                                                           // [R1]
            (
                .clock    (clock),
                .arst_n   (arst_n),
                .inData   (wb_dat_i),
                .inValid  (qInValid[c]),
                .inReady  (qInReady[c]),
                .outData  (qOutData[c]),
                .outValid (qOutValid[c]),
                .outReady (qOutReady[c])
            );                                                               // [R13]
        end
    endgenerate

    // ---------------------------------------------------------------
    // sticky error flags, one pair per core
    // ---------------------------------------------------------------
    // an error arriving with the clear wins, so no event is lost
    generate
        for (c = 0; c < 2; c++)
        begin : gFlags
            always_ff @(posedge clock or negedge arst_n)
            begin
                if (!arst_n)
                    wrFull_q[c] <= `ICMB_RST_FLAG;                           // [R13]
                else if (pushReq[c] && !txReady[c])
                    wrFull_q[c] <= 1'b1;                                     // [R4]
                else if (clearReq[c])
                    wrFull_q[c] <= 1'b0;                                     // [R7]
            end

            always_ff @(posedge clock or negedge arst_n)
            begin
                if (!arst_n)
                    rdEmpty_q[c] <= `ICMB_RST_FLAG;                          // [R13]
                else if (popReq[c] && !rxValid[c])
                    rdEmpty_q[c] <= 1'b1;                                    // [R3]
                else if (clearReq[c])
                    rdEmpty_q[c] <= 1'b0;                                    // [R7]
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // read data and acknowledge
    // ---------------------------------------------------------------
    // status shows the live queue state of the addressed core
    function automatic icmb_word_t statusWord(input logic cr);
        icmb_word_t w;
        w                    = `ICMB_RST_WORD;
        w[`ICMB_ST_RXVALID]  = rxValid[cr];                                  // [R6]
        w[`ICMB_ST_TXREADY]  = txReady[cr];                                  // [R5]
        w[`ICMB_ST_WRFULL]   = wrFull_q[cr];                                 // [R4]
        w[`ICMB_ST_RDEMPTY]  = rdEmpty_q[cr];                                // [R3]
        return w;
    endfunction

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            ack_q <= 1'b0;
        else
            ack_q <= request;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            rdData_q <= `ICMB_RST_WORD;
        else if (request)
        begin
            if (wb_we_i)
                rdData_q <= `ICMB_RST_WORD;
            else
            begin
                case (regSel)
                    ICMB_REG_STATUS:
                        rdData_q <= statusWord(bank);
                    ICMB_REG_RXDATA:
                        // an ignored pop returns zero and leaves the queue alone
                        rdData_q <= rxValid[bank] ? rxHead[bank]             // [R12]
                                                  : `ICMB_RST_WORD;         // [R3]
                    default:
                        rdData_q <= `ICMB_RST_WORD;
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // interrupt per core
    // ---------------------------------------------------------------
    // valid only falls when the queue runs empty, never on an error clear
    generate
        for (c = 0; c < 2; c++)
        begin : gIrq
            always_ff @(posedge clock or negedge arst_n)
            begin
                if (!arst_n)
                    irq_q[c] <= `ICMB_RST_FLAG;
                else
                    irq_q[c] <= rxValid[c] || wrFull_q[c] || rdEmpty_q[c];   // [R7] [R8]
            end
        end
    endgenerate

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdData_q;
    assign coreIrq  = irq_q;

endmodule

`default_nettype wire

// ==== test/icmb_mailbox_properties.sv ====
// checker: bus timing and status/interrupt relations of the mailbox
`timescale 1ns/1ps
`default_nettype none

module icmb_mailbox_checker
(
    input wire logic                 clock,
    input wire logic                 arst_n,
    input wire logic                 wb_cyc_i,
    input wire logic                 wb_stb_i,
    input wire logic                 wb_we_i,
    input wire icmb_pkg::icmb_addr_t wb_adr_i,
    input wire icmb_pkg::icmb_word_t wb_dat_o,
    input wire logic                 wb_ack_o,
    input wire icmb_pkg::icmb_pair_t coreIrq
);
    import icmb_pkg::*;

    default clocking @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    // ------------------------------------------------------------
    // steps of an access
    // ------------------------------------------------------------
    sequence take_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence rdSt_s;
        take_s ##0 (!wb_we_i && wb_adr_i[3:0] == 4'h0);
    endsequence
    sequence rdNone_s;
        take_s ##0 (!wb_we_i && wb_adr_i[3:0] == 4'hC);
    endsequence

    a_ack_latency: assert property (take_s |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property
        (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
        else $error("ack without request");
    a_dat_hold: assert property
        (!(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> $stable(wb_dat_o))
        else $error("read data moved while idle");
    a_status_upper: assert property (rdSt_s |=> wb_dat_o[31:4] == 28'h0)
        else $error("status upper bits not zero");
    a_unmapped_zero: assert property (rdNone_s |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_irq_matches: assert property
        (rdSt_s |=> coreIrq[$past(wb_adr_i[4])] == (wb_dat_o[0] | wb_dat_o[2] | wb_dat_o[3]))
        else $error("interrupt disagrees with status");
    a_irq_reset: assert property ($rose(arst_n) |-> coreIrq == 2'b00)
        else $error("interrupt high after reset");
endmodule

bind icmb_mailbox icmb_mailbox_checker checker_i (.clock, .arst_n, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .coreIrq);

`default_nettype wire

// ==== test/icmb_core_model.sv ====
// bus master model standing in for both processor cores
`timescale 1ns/1ps
`default_nettype none

module icmb_core_model
(
    input  wire logic                 clock,
    output logic                      cyc,
    output logic                      stb,
    output logic                      we,
    output icmb_pkg::icmb_addr_t      adr,
    output icmb_pkg::icmb_sel_t       sel,
    output icmb_pkg::icmb_word_t      datOut,
    input  wire icmb_pkg::icmb_word_t datIn,
    input  wire logic                 ack
);
    import icmb_pkg::*;

    initial
    begin
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'hFF;
        sel = 4'h0;
        datOut = 32'h0;
    end

    // one shared bus; the bank bit of the address says which core speaks
    task automatic xfer(input logic w, input icmb_addr_t a, input icmb_sel_t s,
                        input icmb_word_t d, output icmb_word_t q);
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        datOut <= d;
        do @(posedge clock); while (ack !== 1'b1);
        q = datIn;
        cyc <= 1'b0;
        stb <= 1'b0;
        // released lines show the inverse so a stale value never looks valid
        adr <= ~a;
        datOut <= ~d;
        sel <= ~s;
    endtask
endmodule

`default_nettype wire

// ==== test/tb_top.sv ====
// self-checking bench for the inter-core mailbox
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import icmb_pkg::*;

    logic       clock;
    logic       arst_n;
    logic       cyc;
    logic       stb;
    logic       we;
    logic       ack;
    icmb_addr_t adr;
    icmb_sel_t  sel;
    icmb_word_t datW;
    icmb_word_t datR;
    icmb_word_t rd;
    icmb_pair_t coreIrq;
    int         failCount;
    int         samplesChecked;

    icmb_mailbox DUT (.clock(clock), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR),
        .wb_ack_o(ack), .coreIrq(coreIrq));
    icmb_core_model core (.clock(clock), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
        .sel(sel), .datOut(datW), .datIn(datR), .ack(ack));

    task automatic chk(input icmb_word_t seen, input icmb_word_t exp);
        samplesChecked++;
        if (seen !== exp)
        begin
            failCount++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input icmb_addr_t a, input icmb_word_t d);
        core.xfer(1'b1, a, 4'hF, d, rd);
    endtask
    task automatic rdc(input icmb_addr_t a, input icmb_word_t e);
        core.xfer(1'b0, a, 4'hF, 32'h0, rd);
        chk(rd, e);
    endtask
    task automatic reportAndStop;
        $display("checks %0d mismatches %0d", samplesChecked, failCount);
        if (failCount == 0 && samplesChecked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // the tests need a few hundred cycles; this allows two thousand
    initial
    begin
        #200_000;
        failCount++;
        reportAndStop();
    end

    initial
    begin
        arst_n = 1'b0;
        failCount = 0;
        samplesChecked = 0;
        repeat (12) @(posedge clock);
        arst_n <= 1'b1;
        rdc(8'h10, 32'h2);
        for (int i = 0; i < 8; i++)
        begin
            rdc(8'h00, 32'h2);
            wr(8'h04, 32'hC0DE_0000 + i);
        end
        rdc(8'h00, 32'h0);
        rdc(8'h10, 32'h3);
        wr(8'h04, 32'hDEAD_BEEF);
        rdc(8'h00, 32'h4);
        rdc(8'h08, 32'h0);
        rdc(8'h00, 32'hC);
        chk({30'h0, coreIrq}, 32'h3);
        wr(8'h00, 32'h0);
        rdc(8'h00, 32'h0);
        chk({30'h0, coreIrq}, 32'h2);
        wr(8'h10, 32'h0);
        rdc(8'h10, 32'h3);
        for (int i = 0; i < 8; i++)
        begin
            rdc(8'h10, 32'h3);
            rdc(8'h18, 32'hC0DE_0000 + i);
        end
        rdc(8'h10, 32'h2);
        chk({30'h0, coreIrq}, 32'h0);
        // core one: pop when empty, then one push too many
        rdc(8'h18, 32'h0);
        rdc(8'h10, 32'hA);
        for (int i = 0; i < 9; i++)
            wr(8'h14, 32'h1000_0000 + i);
        rdc(8'h10, 32'hC);
        chk({30'h0, coreIrq}, 32'h3);
        wr(8'h10, 32'h0);
        rdc(8'h10, 32'h0);
        chk({30'h0, coreIrq}, 32'h1);
        for (int i = 0; i < 8; i++)
            rdc(8'h08, 32'h1000_0000 + i);
        rdc(8'h00, 32'h2);
        // refused writes: into a receive port, with partial lanes, to a hole
        wr(8'h18, 32'h1234_5678);
        core.xfer(1'b1, 8'h14, 4'h3, 32'h5555_AAAA, rd);
        wr(8'h1C, 32'hFFFF_FFFF);
        rdc(8'h1C, 32'h0);
        rdc(8'h00, 32'h2);
        wr(8'h14, 32'h8765_4321);
        rdc(8'h00, 32'h3);
        rdc(8'h08, 32'h8765_4321);
        wr(8'h04, 32'h1);
        @(posedge clock);
        arst_n <= 1'b0;
        @(posedge clock);
        arst_n <= 1'b1;
        rdc(8'h10, 32'h2);
        reportAndStop();
    end
endmodule

`default_nettype wire
